/* rtl/pfs_sched.v */
// Purpose: row scheduler and unit timing for packed-fp work
// Assumes: decoder, cache and fp cores run on CLK_SYS
// Notes:   result data of the fp cores enters on MUL_RES/ALU_RES
`timescale 1ns/1ps
`include "pfs_map.vh"

// Behaviour
// - each row holds exactly four ops
// - a decoded pair enters as one row
// - prefetch-for-write holds decoder two cycles
// - load result after two or three cycles
// - multiply result two cycles after start
// - add, accumulate, alu results after two cycles
// - six-stage scheduler depth
// - alu and multiplier issue in same cycle
// - load data forwarded at completion
// - multiplier result forwarded to dependents
// - one load per cycle, other waits
// - separate load and store units
// - store data accepted up to two cycles late (code waits for data with no cycle limit)
// - eight 64-bit registers
// - prefetch fills line without stalling others
// - line of eight doublewords
// - loop branch costs compare plus branch
// - buffer holds six rows, 24 entries
// - full buffer stalls the decoder
// - incomplete bottom row stalls retirement
module pfs_sched (
    input  wire                              CLK_SYS,
    input  wire                              RESETN,
    input  wire                              CE,
    input  wire                              DEC_VALID,
    input  wire [`PFS_OPS_ROW*`PFS_OP_W-1:0] DEC_OPS,
    output wire                              DEC_READY,
    input  wire                              DC_FAST,
    input  wire [`PFS_REG_W-1:0]             LD_DATA,
    input  wire [`PFS_REG_W-1:0]             MUL_RES,
    input  wire [`PFS_REG_W-1:0]             ALU_RES,
    output reg                               LD_GO,
    output reg  [31:0]                       LD_ADDR,
    output wire                              LD_DONE,
    output reg                               ST_GO,
    output reg  [31:0]                       ST_ADDR,
    output reg  [`PFS_REG_W-1:0]             ST_DATA,
    output reg                               MUL_GO,
    output reg  [`PFS_REG_W-1:0]             MUL_A,
    output reg  [`PFS_REG_W-1:0]             MUL_B,
    output reg                               ALU_GO,
    output reg  [`PFS_REG_W-1:0]             ALU_A,
    output reg  [`PFS_REG_W-1:0]             ALU_B,
    output reg                               PF_GO,
    output reg                               PF_WRITE,
    output reg  [31-`PFS_LINE_SH:0]          PF_LINE,
    output reg                               BR_GO,
    output reg                               RET_GO,
    output wire [2:0]                        ROWS_USED
);
    // scheduler storage
    reg [`PFS_OP_W-1:0]    op_r [0:`PFS_ENTRIES-1]; // op words
    reg [`PFS_ENTRIES-1:0] iss_r;                   // issued flags
    reg [`PFS_ENTRIES-1:0] done_r;                  // complete flags
    reg [2:0]              head_r;                  // bottom row
    reg [2:0]              cnt_r;                   // rows in use
    reg                    pfw_hold_r;              // decoder busy
    reg [`PFS_ENTRIES-1:0] iss_nxt;
    reg [`PFS_ENTRIES-1:0] done_nxt;

    // store unit
    reg                    st_busy_r;               // waiting for data
    reg [2:0]              st_reg_r;                // data register
    reg [`PFS_TAG_W-1:0]   st_tag_r;                // owning entry
    reg [31:0]             st_addr_r;               // captured address

    // scan results
    reg [`PFS_ENTRIES-1:0] iss_mask;
    reg [`PFS_ENTRIES-1:0] imm_done;
    reg [`PFS_ENTRIES-1:0] cmp_now;
    reg                    ld_t, st_t, mu_t, al_t, pf_t, br_t;
    reg [`PFS_TAG_W-1:0]   ld_e, st_e, mu_e, al_e, pf_e;
    reg                    st_blk;
    reg [7:0]              wm_all;                  // older pending writers
    reg [7:0]              wm_unis;                 // older unissued writers
    reg [7:0]              rm;                      // older unissued readers, busy store data
    reg [2:0]              c, d, s;
    reg                    ud, us, wr, rdy, go;
    integer                p, e, n, m;

    // unit pipes
    wire                   ld_ov, mu_ov, al_ov;
    wire [7:0]             ld_od, mu_od, al_od;
    wire [`PFS_REGS*`PFS_REG_W-1:0] rf_flat;

    wire                   acc;
    wire                   ret;
    wire                   st_take;
    wire [`PFS_ENTRIES-1:0] dsh;
    wire [2:0]             tail;
    wire [4:0]             t4;
    wire                   row_pfw;

    // read one register out of the flat file
    function [`PFS_REG_W-1:0] rd;
        input [`PFS_REGS*`PFS_REG_W-1:0] f;
        input [2:0]                      r;
        begin
            rd = f[r*`PFS_REG_W +: `PFS_REG_W];
        end
    endfunction

    // row index wrap over six rows
    function [2:0] wrap6;
        input [3:0] v;
        begin
            wrap6 = (v >= `PFS_ROWS) ? v[2:0] - 3'h6 : v[2:0];
        end
    endfunction

    // class writes its destination register
    function writes;
        input [2:0] k;
        begin
            writes = (k == `PFS_C_LOAD) || (k == `PFS_C_MUL) || (k == `PFS_C_ALU);
        end
    endfunction

    // row geometry
    assign tail      = wrap6({1'b0, head_r} + {1'b0, cnt_r});
    assign t4        = {tail, 2'b00};
    assign dsh       = done_r >> {head_r, 2'b00};
    assign ROWS_USED = cnt_r;

    // decoder stalls while full or a prefetch-for-write decodes
    assign DEC_READY = (cnt_r != 3'h6) && !pfw_hold_r;
    assign acc       = CE && DEC_VALID && DEC_READY;

    // retire bottom row only when all four ops are complete
    assign ret       = (cnt_r != 3'h0) && (&dsh[3:0]);

    // a prefetch-for-write in the row takes the long decode path
    assign row_pfw   = (DEC_OPS[8:6] == `PFS_C_PFW) || (DEC_OPS[17:15] == `PFS_C_PFW)
                    || (DEC_OPS[26:24] == `PFS_C_PFW) || (DEC_OPS[35:33] == `PFS_C_PFW);

    // store data taken when no older producer is pending
    assign st_take   = st_busy_r && !st_blk;
    assign LD_DONE   = ld_ov;

    // load unit: two cycles on a fast cache answer while stage one is free, else three
    pfs_lat_pipe #(
        .LAT (`PFS_LD_LAT),
        .W   (8)
    ) u_ld (
        .clk      (CLK_SYS),
        .rstn     (RESETN),
        .ce       (CE),
        .in_v     (ld_t),
        .in_short (DC_FAST),
        .in_d     ({ld_e, d}),
        .out_v    (ld_ov),
        .out_d    (ld_od)
    );

    // multiplier unit, two cycles
    pfs_lat_pipe #(
        .LAT (`PFS_MUL_LAT),
        .W   (8)
    ) u_mul (
        .clk      (CLK_SYS),
        .rstn     (RESETN),
        .ce       (CE),
        .in_v     (mu_t),
        .in_short (1'b0),
        .in_d     ({mu_e, op_r[mu_e][`PFS_F_DST]}),
        .out_v    (mu_ov),
        .out_d    (mu_od)
    );

    // add, accumulate and alu unit, two cycles
    pfs_lat_pipe #(
        .LAT (`PFS_ALU_LAT),
        .W   (8)
    ) u_alu (
        .clk      (CLK_SYS),
        .rstn     (RESETN),
        .ce       (CE),
        .in_v     (al_t),
        .in_short (1'b0),
        .in_d     ({al_e, op_r[al_e][`PFS_F_DST]}),
        .out_v    (al_ov),
        .out_d    (al_od)
    );

    // architectural registers with completion bypass
    pfs_regfile u_rf (
        .clk  (CLK_SYS),
        .rstn (RESETN),
        .ce   (CE),
        .we0  (ld_ov),
        .wa0  (ld_od[2:0]),
        .wd0  (LD_DATA),
        .we1  (mu_ov),
        .wa1  (mu_od[2:0]),
        .wd1  (MUL_RES),
        .we2  (al_ov),
        .wa2  (al_od[2:0]),
        .wd2  (ALU_RES),
        .flat (rf_flat)
    );

    // entries completing this cycle
    always @*
    begin
        cmp_now = {`PFS_ENTRIES{1'b0}};
        if (ld_ov)
            cmp_now[ld_od[7:3]] = 1'b1;
        if (mu_ov)
            cmp_now[mu_od[7:3]] = 1'b1;
        if (al_ov)
            cmp_now[al_od[7:3]] = 1'b1;
        if (st_take)
            cmp_now[st_tag_r] = 1'b1;
    end

    // oldest-first issue scan over the buffer
    always @*
    begin
        iss_mask = {`PFS_ENTRIES{1'b0}};
        imm_done = {`PFS_ENTRIES{1'b0}};
        ld_t = 1'b0; st_t = 1'b0; mu_t = 1'b0;
        al_t = 1'b0; pf_t = 1'b0; br_t = 1'b0;
        ld_e = 5'h0; st_e = 5'h0; mu_e = 5'h0;
        al_e = 5'h0; pf_e = 5'h0;
        st_blk = 1'b0;
        wm_all = 8'h0;
        wm_unis = 8'h0;
        rm = st_busy_r ? (8'h1 << st_reg_r) : 8'h0;
        c = 3'h0; d = 3'h0; s = 3'h0;
        ud = 1'b0; us = 1'b0; wr = 1'b0; rdy = 1'b0; go = 1'b0;
        for (p = 0; p < `PFS_ENTRIES; p = p + 1)
        begin
            e = head_r * 4 + p;
            if (e >= `PFS_ENTRIES)
                e = e - `PFS_ENTRIES;
            if (p < cnt_r * 4)
            begin
                c  = op_r[e][`PFS_F_CLS];
                d  = op_r[e][`PFS_F_DST];
                s  = op_r[e][`PFS_F_SRC];
                ud = (c == `PFS_C_MUL) || (c == `PFS_C_ALU) || (c == `PFS_C_STORE);
                us = (c != `PFS_C_NOP) && (c != `PFS_C_BR);
                wr = writes(c);
                go = 1'b0;
                // store sees only older issued producers for its data
                if (st_busy_r && e[4:0] == st_tag_r)
                    st_blk = wm_all[st_reg_r];
                rdy = !(us && ((c == `PFS_C_STORE) ? wm_unis[s] : wm_all[s]))
                    && !(ud && wm_all[d])
                    && !(wr && (wm_all[d] || rm[d]));
                if (!iss_r[e] && !done_r[e] && rdy)
                begin
                    case (c)
                        `PFS_C_LOAD:
                        begin
                            // single load port, younger waits a cycle
                            if (!ld_t)
                            begin
                                ld_t = 1'b1;
                                ld_e = e[4:0];
                                go = 1'b1;
                            end
                        end
                        `PFS_C_STORE:
                        begin
                            // own store port beside the load port
                            if (!st_t && !st_busy_r)
                            begin
                                st_t = 1'b1;
                                st_e = e[4:0];
                                go = 1'b1;
                            end
                        end
                        `PFS_C_MUL:
                        begin
                            // independent of the alu unit
                            if (!mu_t)
                            begin
                                mu_t = 1'b1;
                                mu_e = e[4:0];
                                go = 1'b1;
                            end
                        end
                        `PFS_C_ALU:
                        begin
                            if (!al_t)
                            begin
                                al_t = 1'b1;
                                al_e = e[4:0];
                                go = 1'b1;
                            end
                        end
                        `PFS_C_PFW, `PFS_C_PF:
                        begin
                            // fill starts, op completes at once
                            if (!pf_t)
                            begin
                                pf_t = 1'b1;
                                pf_e = e[4:0];
                                go = 1'b1;
                                imm_done[e] = 1'b1;
                            end
                        end
                        `PFS_C_BR:
                        begin
                            // loop branch, one cycle like compare+branch
                            if (!br_t)
                            begin
                                br_t = 1'b1;
                                go = 1'b1;
                                imm_done[e] = 1'b1;
                            end
                        end
                        default:
                        begin
                            go = 1'b0;
                        end
                    endcase
                end
                if (go)
                    iss_mask[e] = 1'b1;
                // younger ops see this one as a pending writer or reader
                if (wr && !done_r[e] && !cmp_now[e])
                    wm_all[d] = 1'b1;
                if (wr && !iss_r[e] && !go)
                    wm_unis[d] = 1'b1;
                if (!iss_r[e] && !go && us)
                    rm[s] = 1'b1;
                if (!iss_r[e] && !go && ud)
                    rm[d] = 1'b1;
            end
        end
        // load destination for the pipe payload
        d = op_r[ld_e][`PFS_F_DST];
    end

    // next issued and complete flags
    always @*
    begin
        iss_nxt  = iss_r | iss_mask;
        done_nxt = done_r | cmp_now | imm_done;
        if (acc)
        begin
            for (n = 0; n < `PFS_OPS_ROW; n = n + 1)
            begin
                iss_nxt[t4 + n]  = 1'b0;
                done_nxt[t4 + n] = (DEC_OPS[n*`PFS_OP_W + 6 +: 3] == `PFS_C_NOP);
            end
        end
    end

    // row bookkeeping: one pair in as one row of four ops
    always @(posedge CLK_SYS)
    begin
        if (!RESETN)
        begin
            head_r     <= 3'h0;
            cnt_r      <= 3'h0;
            iss_r      <= {`PFS_ENTRIES{1'b0}};
            done_r     <= {`PFS_ENTRIES{1'b0}};
            pfw_hold_r <= 1'b0;
            RET_GO     <= 1'b0;
        end
        else if (CE)
        begin
            iss_r      <= iss_nxt;
            done_r     <= done_nxt;
            RET_GO     <= ret;
            // second decode cycle of a prefetch-for-write
            pfw_hold_r <= acc && row_pfw;
            if (ret)
                head_r <= wrap6({1'b0, head_r} + 4'h1);
            cnt_r <= cnt_r + {2'b00, acc} - {2'b00, ret};
            if (acc)
            begin
                for (m = 0; m < `PFS_OPS_ROW; m = m + 1)
                    op_r[t4 + m] <= DEC_OPS[m*`PFS_OP_W +: `PFS_OP_W];
            end
        end
    end

    // unit strobes and operands, all from flops
    always @(posedge CLK_SYS)
    begin
        if (!RESETN)
        begin
            LD_GO     <= 1'b0;
            LD_ADDR   <= 32'h0;
            ST_GO     <= 1'b0;
            ST_ADDR   <= 32'h0;
            ST_DATA   <= 64'h0;
            MUL_GO    <= 1'b0;
            MUL_A     <= 64'h0;
            MUL_B     <= 64'h0;
            ALU_GO    <= 1'b0;
            ALU_A     <= 64'h0;
            ALU_B     <= 64'h0;
            PF_GO     <= 1'b0;
            PF_WRITE  <= 1'b0;
            PF_LINE   <= 27'h0;
            BR_GO     <= 1'b0;
            st_busy_r <= 1'b0;
            st_reg_r  <= 3'h0;
            st_tag_r  <= 5'h0;
            st_addr_r <= 32'h0;
        end
        else if (CE)
        begin
            LD_GO  <= ld_t;
            MUL_GO <= mu_t;
            ALU_GO <= al_t;
            PF_GO  <= pf_t;
            BR_GO  <= br_t;
            ST_GO  <= st_take;
            // operands include results completing now
            if (ld_t)
                LD_ADDR <= rf_flat[op_r[ld_e][`PFS_F_SRC]*`PFS_REG_W +: 32];
            if (mu_t)
            begin
                MUL_A <= rd(rf_flat, op_r[mu_e][`PFS_F_DST]);
                MUL_B <= rd(rf_flat, op_r[mu_e][`PFS_F_SRC]);
            end
            if (al_t)
            begin
                ALU_A <= rd(rf_flat, op_r[al_e][`PFS_F_DST]);
                ALU_B <= rd(rf_flat, op_r[al_e][`PFS_F_SRC]);
            end
            // line index of a 32-byte line
            if (pf_t)
            begin
                PF_WRITE <= (op_r[pf_e][`PFS_F_CLS] == `PFS_C_PFW);
                PF_LINE  <= rf_flat[op_r[pf_e][`PFS_F_SRC]*`PFS_REG_W+`PFS_LINE_SH +: 32-`PFS_LINE_SH];
            end
            // store issues on address, data follows when produced
            if (st_t)
            begin
                st_busy_r <= 1'b1;
                st_reg_r  <= op_r[st_e][`PFS_F_SRC];
                st_tag_r  <= st_e;
                st_addr_r <= rf_flat[op_r[st_e][`PFS_F_DST]*`PFS_REG_W +: 32];
            end
            else if (st_take)
                st_busy_r <= 1'b0;
            if (st_take)
            begin
                ST_ADDR <= st_addr_r;
                ST_DATA <= rd(rf_flat, st_reg_r);
            end
        end
    end
endmodule

/* rtl/pfs_map.vh */
// Purpose: shared constants of the packed-fp scheduler timing block
// Assumes: included by the pfs_sched and pfs_regfile design files
// Notes:   definitions only
`ifndef PFS_MAP_VH
`define PFS_MAP_VH

// scheduler geometry
`define PFS_ROWS        6
`define PFS_OPS_ROW     4
`define PFS_ENTRIES     24
`define PFS_OP_W        9
`define PFS_TAG_W       5

// register file
`define PFS_REGS        8
`define PFS_REG_W       64
`define PFS_RA_W        3

// op word layout: class, destination, source
`define PFS_F_CLS       8:6
`define PFS_F_DST       5:3
`define PFS_F_SRC       2:0

// op classes
`define PFS_C_NOP       3'h0
`define PFS_C_LOAD      3'h1
`define PFS_C_STORE     3'h2
`define PFS_C_MUL       3'h3
`define PFS_C_ALU       3'h4
`define PFS_C_PFW       3'h5
`define PFS_C_PF        3'h6
`define PFS_C_BR        3'h7

// timing in core cycles
`define PFS_LD_LAT      3
`define PFS_LD_LAT_MIN  2
`define PFS_MUL_LAT     2
`define PFS_ALU_LAT     2
`define PFS_ST_SLACK    2
`define PFS_PFW_DEC     2
`define PFS_BR_LAT      1

// data cache line: eight doublewords of 4 bytes
`define PFS_LINE_DW     8
`define PFS_LINE_SH     5

`endif

/* rtl/pfs_lat_pipe.v */
// Purpose: fixed-latency tracker for one execution unit
// Assumes: one issue per cycle at most
// Notes:   a short issue enters one stage late when stage one is free, cutting one cycle
`timescale 1ns/1ps
module pfs_lat_pipe #(
    parameter LAT = 2,
    parameter W   = 8
) (
    input  wire         clk,
    input  wire         rstn,
    input  wire         ce,
    input  wire         in_v,
    input  wire         in_short,
    input  wire [W-1:0] in_d,
    output wire         out_v,
    output wire [W-1:0] out_d
);
    reg [LAT-1:0] v_r;              // stage valid bits
    reg [W-1:0]   d_r [0:LAT-1];    // stage payloads
    wire          sh;               // short path granted
    integer       i;

    // short only when stage one will not be taken by an older issue
    assign sh = in_short && !v_r[0] && (LAT > 1);

    // shift the issue tags toward completion
    always @(posedge clk)
    begin
        if (!rstn)
            v_r <= {LAT{1'b0}};
        else if (ce)
        begin
            v_r[0] <= in_v && !sh;
            d_r[0] <= in_d;
            for (i = 1; i < LAT; i = i + 1)
            begin
                v_r[i] <= v_r[i-1];
                d_r[i] <= d_r[i-1];
            end
            if (in_v && sh)
            begin
                v_r[LAT > 1 ? 1 : 0] <= 1'b1;
                d_r[LAT > 1 ? 1 : 0] <= in_d;
            end
        end
    end

    assign out_v = v_r[LAT-1];
    assign out_d = d_r[LAT-1];
endmodule

/* rtl/pfs_regfile.v */
// Purpose: eight 64-bit registers, each two packed single values
// Assumes: write ports never hit the same register in one cycle
// Notes:   reads see this cycle's writes (forwarding path)
`timescale 1ns/1ps
`include "pfs_map.vh"
module pfs_regfile (
    input  wire                          clk,
    input  wire                          rstn,
    input  wire                          ce,
    input  wire                          we0,
    input  wire [`PFS_RA_W-1:0]          wa0,
    input  wire [`PFS_REG_W-1:0]         wd0,
    input  wire                          we1,
    input  wire [`PFS_RA_W-1:0]          wa1,
    input  wire [`PFS_REG_W-1:0]         wd1,
    input  wire                          we2,
    input  wire [`PFS_RA_W-1:0]          wa2,
    input  wire [`PFS_REG_W-1:0]         wd2,
    output reg  [`PFS_REGS*`PFS_REG_W-1:0] flat
);
    reg [`PFS_REG_W-1:0] mem [0:`PFS_REGS-1];  // architectural regs
    integer i, j;

    // write at completion
    always @(posedge clk)
    begin
        if (!rstn)
        begin
            for (j = 0; j < `PFS_REGS; j = j + 1)
                mem[j] <= 64'h0;
        end
        else if (ce)
        begin
            if (we0)
                mem[wa0] <= wd0;
            if (we1)
                mem[wa1] <= wd1;
            if (we2)
                mem[wa2] <= wd2;
        end
    end

    // bypass completing results to readers
    always @*
    begin
        for (i = 0; i < `PFS_REGS; i = i + 1)
        begin
            if (we0 && wa0 == i[2:0])
                flat[i*`PFS_REG_W +: `PFS_REG_W] = wd0;
            else if (we1 && wa1 == i[2:0])
                flat[i*`PFS_REG_W +: `PFS_REG_W] = wd1;
            else if (we2 && wa2 == i[2:0])
                flat[i*`PFS_REG_W +: `PFS_REG_W] = wd2;
            else
                flat[i*`PFS_REG_W +: `PFS_REG_W] = mem[i];
        end
    end
endmodule

/* tb/pfs_sched_asserts.sv */
// Purpose: port-level checker for the packed-fp scheduler
// Assumes: CE held high by the bench
// Notes:   bound to every pfs_sched instance
`timescale 1ns/1ps
module pfs_sched_chk (
    input wire logic        CLK_SYS,
    input wire logic        RESETN,
    input wire logic        CE,
    input wire logic        DEC_VALID,
    input wire logic        DEC_READY,
    input wire logic [35:0] DEC_OPS,
    input wire logic        DC_FAST,
    input wire logic        LD_GO,
    input wire logic        LD_DONE,
    input wire logic        RET_GO,
    input wire logic [2:0]  ROWS_USED
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);
    // row taken this edge, and whether it holds a prefetch-for-write
    wire acc = DEC_VALID && DEC_READY && CE;
    wire pfw = DEC_OPS[8:6] == 3'h5 || DEC_OPS[17:15] == 3'h5 || DEC_OPS[26:24] == 3'h5 || DEC_OPS[35:33] == 3'h5;
    // a load completes one or two cycles after its go pulse
    sequence ld_wait_s;
        ##[1:2] LD_DONE;
    endsequence
    sequence ld_fast_s;
        LD_GO && $past(DC_FAST) && !$past(LD_GO);
    endsequence
    rows_max_a: assert property (ROWS_USED <= 3'h6) else $error("rows used above six");
    full_stall_a: assert property (ROWS_USED == 3'h6 |-> !DEC_READY) else $error("full but ready");
    pfw_hold_a: assert property (acc && pfw |=> !DEC_READY) else $error("no decoder hold");
    ready_why_a: assert property (!DEC_READY |-> ROWS_USED == 3'h6 || $past(acc && pfw))
        else $error("decoder refused without cause");
    rows_track_a: assert property ({1'b0, ROWS_USED} + RET_GO == {1'b0, $past(ROWS_USED)} + $past(acc))
        else $error("row count off");
    ret_rows_a: assert property (RET_GO |-> $past(ROWS_USED) != 3'h0) else $error("retire from empty");
    ld_done_a: assert property (LD_GO |-> ld_wait_s) else $error("load late");
    ld_cause_a: assert property (LD_DONE |-> $past(LD_GO) || $past(LD_GO, 2)) else $error("stray load done");
    ld_fast_a: assert property (ld_fast_s |=> LD_DONE) else $error("fast load slow");
endmodule
bind pfs_sched pfs_sched_chk i_chk (.*);

/* tb/pfs_dec_model.sv */
// Purpose: decoder stand-in offering queued rows
// Assumes: bench pushes rows into q
// Notes:   slow inserts an idle cycle after each taken row
`timescale 1ns/1ps
module pfs_dec_model (
    input  wire logic        clk,
    input  wire logic        ready,
    input  wire logic        slow,
    output logic             valid,
    output logic [35:0]      ops
);
    logic [35:0] q[$];  // rows waiting to be offered
    initial
    begin
        valid = 1'b0;
        ops   = 36'h0;
    end
    // hold a row until taken; idle data toggles so no stale row shows
    always @(posedge clk)
    begin
        if (valid && ready)
            void'(q.pop_front());  // whole row of four ops leaves
        valid <= q.size() != 0 && !(slow && valid && ready);  // waits while refused
        ops   <= q.size() != 0 ? q[0] : ~ops;
    end
endmodule

/* tb/tb.sv */
// Purpose: self-checking bench for pfs_sched
// Assumes: data cache and fp cores are modelled inline
// Notes:   unit go pulses are time stamped for timing checks
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0, rstn = 1'b0, fast = 1'b0, slow = 1'b0;
    logic [63:0] ld_d = 64'h0, mul_r = 64'h0, alu_r = 64'h0;
    logic [27:0] pf_seen;  // write flag and line of last prefetch
    wire dv, dr, ld_go, ld_done, st_go, mul_go, alu_go, pf_go, pf_w, br_go, ret_go;
    wire [35:0] ops;
    wire [31:0] ld_a, st_a;
    wire [63:0] st_d, ma, mb, aa, ab;
    wire [26:0] pf_l;
    wire [2:0] rows;
    int n_fail = 0, checks_done = 0, cyc = 0;
    int f[6], s[6];  // first and second go stamp per unit
    initial forever #4 clk = ~clk;
    pfs_dec_model i_pfs_dec_model (.clk(clk), .ready(dr), .slow(slow), .valid(dv), .ops(ops));
    pfs_sched i_pfs_sched (.CLK_SYS(clk), .RESETN(rstn), .CE(1'b1), .DEC_VALID(dv), .DEC_OPS(ops),
        .DEC_READY(dr), .DC_FAST(fast), .LD_DATA(ld_d), .MUL_RES(mul_r), .ALU_RES(alu_r), .LD_GO(ld_go),
        .LD_ADDR(ld_a), .LD_DONE(ld_done), .ST_GO(st_go), .ST_ADDR(st_a), .ST_DATA(st_d), .MUL_GO(mul_go),
        .MUL_A(ma), .MUL_B(mb), .ALU_GO(alu_go), .ALU_A(aa), .ALU_B(ab), .PF_GO(pf_go), .PF_WRITE(pf_w),
        .PF_LINE(pf_l), .BR_GO(br_go), .RET_GO(ret_go), .ROWS_USED(rows));
    // cache and fp core stand-ins, pulse stamping
    always @(posedge clk)
    begin
        logic [5:0] g;
        g = {br_go, pf_go, alu_go, mul_go, st_go, ld_go};
        cyc++;
        ld_d  <= {ld_a, ~ld_a};
        mul_r <= ma + mb;
        alu_r <= aa ^ ab;
        if (pf_go)
            pf_seen = {pf_w, pf_l};
        for (int k = 0; k < 6; k++)
            if (g[k] && f[k] < 0) f[k] = cyc; else if (g[k] && s[k] < 0) s[k] = cyc;
    end
    function automatic [8:0] op(input [2:0] c, d, r);
        op = {c, d, r};
    endfunction
    task chk(input string what, input logic [63:0] seen, exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task go(input logic [35:0] row);
        f = '{default: -1};
        s = '{default: -1};
        i_pfs_dec_model.q.push_back(row);
    endtask
    task drain(input string name);
        repeat (3) @(posedge clk);
        for (int i = 0; i < 300 && (rows !== 3'h0 || dv !== 1'b0); i++) @(posedge clk);
        chk("drained", {dv, rows}, 0);
        repeat (2) @(posedge clk);
        $display("test %s done", name);
    endtask
    task finish_test;
        $display("checks %0d fails %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // paired loads share one unit, store runs beside them
    task t_loads;
        fast <= 1'b1;
        go({op(0, 0, 0), op(3'h2, 1, 0), op(3'h1, 3, 0), op(3'h1, 2, 0)});
        drain("loads");
        chk("load gap", s[0] - f[0], 1);
        chk("load store", f[1], f[0] + 1);
    endtask
    // independent mul and alu, then dependent chains
    task t_units;
        go({op(0, 0, 0), op(0, 0, 0), op(3'h4, 5, 6), op(3'h3, 7, 4)});
        drain("mul alu");
        chk("dual issue", f[2], f[3]);
        go({op(0, 0, 0), op(0, 0, 0), op(3'h4, 1, 1), op(3'h3, 1, 4)});
        drain("mul dep");
        chk("mul to use", f[3] - f[2], 2);
        for (int k = 0; k < 2; k++)
        begin
            fast <= k[0];
            go({op(0, 0, 0), op(0, 0, 0), op(3'h3, 6, 6), op(3'h1, 6, 0)});
            drain("load dep");
            chk("load to use", f[2] - f[0], 3 - k);
        end
    endtask
    // both prefetch kinds from a loaded address
    task t_pf;
        for (int k = 5; k < 7; k++)
        begin
            go({op(0, 0, 0), op(0, 0, 0), op(3'h4, 4, 4), op(k[2:0], 0, 3)});
            drain("prefetch");
            chk("pf", pf_seen, {k == 5, 27'h7FFFFFF});
        end
    endtask
    // dependent mul rows fill the buffer, then a slow decoder feeds branches
    task t_fill;
        for (int k = 0; k < 8; k++)
            i_pfs_dec_model.q.push_back({4{op(3'h3, 1, 1)}});
        for (int i = 0; i < 100 && rows !== 3'h6; i++) @(posedge clk);
        chk("rows full", rows, 6);
        chk("decoder held", dr, 0);
        drain("fill");
        slow <= 1'b1;
        go({op(0, 0, 0), op(0, 0, 0), op(3'h7, 0, 0), op(3'h7, 0, 0)});
        drain("branch");
        chk("branch pace", s[5] - f[5], 1);
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        finish_test();
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk("ready", dr, 1);
        chk("rows", rows, 0);
        t_loads();
        t_units();
        t_pf();
        t_fill();
        finish_test();
    end
endmodule
